// ---- rtl/iprc_pkg.sv ----
// constants and types shared by the power, reset and programming control
package iprc_pkg;
	// ----------------------------------------------------------------
	// register addresses on the core's register bus
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_ISP_CONTROL = 8'hBF;
	localparam logic [7:0] ADDR_FLASH_ADDR_LOW = 8'hC4;
	localparam logic [7:0] ADDR_FLASH_ADDR_HIGH = 8'hC5;
	localparam logic [7:0] ADDR_FLASH_DATA = 8'hC6;
	localparam logic [7:0] ADDR_FLASH_COMMAND = 8'hC7;
	localparam logic [7:0] ADDR_NIBBLE_PORT = 8'hD8;
	localparam logic [7:0] ADDR_ISP_UNLOCK = 8'hF6;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_POWER_CONTROL = 8'h30;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [3:0] RST_NIBBLE_PORT = 4'hF;
	localparam logic [7:0] RST_PORT = 8'hFF;
	localparam logic [7:0] RST_STACK_PTR = 8'h07;
	localparam logic [7:0] POWER_CONTROL_KEEP = 8'h10;
	// ----------------------------------------------------------------
	// bit positions
	// ----------------------------------------------------------------
	localparam int IDLE_REQUEST_BIT = 0;
	localparam int POWERDOWN_REQUEST_BIT = 1;
	localparam int PROGRAM_ENABLE = 0;
	localparam int BOOT_SELECT = 1;
	localparam int AUX_RAM_ENABLE = 4;
	localparam int SOFT_RESET_BIT = 7;
	localparam logic [7:0] ISP_CONTROL_WMASK = 8'h13;
	localparam logic [7:0] SOFT_RESET_PATTERN = 8'h83;
	localparam int BANK_SELECT = 6;
	localparam int FLASH_OUTPUT_ENABLE = 5;
	localparam int FLASH_CHIP_ENABLE = 4;
	localparam logic [7:0] FLASH_COMMAND_WMASK = 8'h7F;
	// ----------------------------------------------------------------
	// unlock values and flash operations
	// ----------------------------------------------------------------
	localparam logic [7:0] UNLOCK_FIRST = 8'h87;
	localparam logic [7:0] UNLOCK_SECOND = 8'h59;
	localparam logic [3:0] OP_ERASE = 4'h2;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_READ = 4'h0;
	// ----------------------------------------------------------------
	// machine cycle timing in oscillator clocks
	// ----------------------------------------------------------------
	localparam int MCYC_CLKS = 12;
	localparam logic [3:0] MCYC_LAST = 4'hB;
	localparam logic [3:0] STATE5_PHASE2 = 4'h9;
	localparam logic [1:0] RST_SAMPLES = 2'h2;
	// ----------------------------------------------------------------
	// state encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_IDLE = 2'b01,
		PWR_DOWN = 2'b10
	} iprc_pwr_e;
	typedef enum logic [1:0] {
		LOCK_CLOSED = 2'b00,
		LOCK_HALF = 2'b01,
		LOCK_OPEN = 2'b10
	} iprc_lock_e;
endpackage : iprc_pkg

// ---- rtl/iprc_top.sv ----
// power modes, reset filter, nibble port and in-system programming control
`timescale 1ns/100ps
module iprc_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic rst_pin,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic irq_any,
	input wire logic ext_irq_line_zero,
	input wire logic ext_irq_line_one,
	input wire logic interrupt_return_exec,
	input wire logic osc_gain_bit,
	input wire logic flash_done,
	input wire logic [7:0] flash_rdata,
	output logic [7:0] sfr_rdata,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_run,
	output logic osc_half_gain,
	output logic core_rst,
	output logic [3:0] nibble_port_pins,
	output logic code_from_loader,
	output logic aux_ram_en,
	output logic pc_clear,
	output logic interrupt_return_to_zero,
	output logic flash_req,
	output logic flash_bank,
	output logic [3:0] flash_op,
	output logic [15:0] flash_addr,
	output logic [7:0] flash_wdata
);
	// ----------------------------------------------------------------
	// state of the block
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pin_meta;
		logic pin_sync;
		logic [3:0] mcyc;
		logic [1:0] hi_cnt;
		logic core_rst;
		iprc_pkg::iprc_pwr_e pwr;
		iprc_pkg::iprc_lock_e lock;
		logic [7:0] power_control;
		logic [7:0] ispc;
		logic [7:0] addr_lo;
		logic [7:0] addr_hi;
		logic [7:0] fdata;
		logic [7:0] fcmd;
		logic [3:0] nport;
		logic cpu_en;
		logic periph_en;
		logic osc_on;
		logic half_gain;
		logic gain_taken;
		logic isp_mode;
		logic loader;
		logic pc_clear;
		logic interrupt_return_zero;
		logic flash_req;
		logic flash_busy;
		logic flash_is_read;
		logic [7:0] rdata;
	} iprc_state_s;

	localparam iprc_state_s ST_RST = '{
		pin_meta: 1'b0, pin_sync: 1'b0, mcyc: 4'h0, hi_cnt: 2'h0,
		core_rst: 1'b1, pwr: iprc_pkg::PWR_RUN,
		lock: iprc_pkg::LOCK_CLOSED,
		power_control: iprc_pkg::RST_POWER_CONTROL, ispc: iprc_pkg::RST_ZERO,
		addr_lo: iprc_pkg::RST_ZERO, addr_hi: iprc_pkg::RST_ZERO,
		fdata: iprc_pkg::RST_ZERO, fcmd: iprc_pkg::RST_ZERO,
		nport: iprc_pkg::RST_NIBBLE_PORT, cpu_en: 1'b1,
		periph_en: 1'b1, osc_on: 1'b1, half_gain: 1'b0,
		gain_taken: 1'b0, isp_mode: 1'b0, loader: 1'b0,
		pc_clear: 1'b0, interrupt_return_zero: 1'b0, flash_req: 1'b0,
		flash_busy: 1'b0, flash_is_read: 1'b0,
		rdata: iprc_pkg::RST_ZERO
	};

	iprc_state_s s;
	iprc_state_s n;
	logic wr_power_control;
	logic wr_ispc;
	logic wr_unlock;
	logic soft_hit;
	logic op_valid;
	logic pd_wake;

	// ----------------------------------------------------------------
	// decode of register writes and flash command
	// ----------------------------------------------------------------
	// writes to the power and control registers
	assign wr_power_control = sfr_wr && (sfr_addr == iprc_pkg::ADDR_POWER_CONTROL);
	assign wr_ispc = sfr_wr && (sfr_addr == iprc_pkg::ADDR_ISP_CONTROL);
	assign wr_unlock = sfr_wr && (sfr_addr == iprc_pkg::ADDR_ISP_UNLOCK);
	// soft reset only with boot select and program enable alongside
	assign soft_hit = wr_ispc && (s.lock == iprc_pkg::LOCK_OPEN) &&
		((sfr_wdata & iprc_pkg::SOFT_RESET_PATTERN) ==
		iprc_pkg::SOFT_RESET_PATTERN);
	// legal command: chip enable low, output enable matches operation
	assign op_valid = !s.fcmd[iprc_pkg::FLASH_CHIP_ENABLE] && (
		(((s.fcmd[3:0] == iprc_pkg::OP_ERASE) ||
		(s.fcmd[3:0] == iprc_pkg::OP_PROGRAM)) &&
		s.fcmd[iprc_pkg::FLASH_OUTPUT_ENABLE]) ||
		((s.fcmd[3:0] == iprc_pkg::OP_READ) &&
		!s.fcmd[iprc_pkg::FLASH_OUTPUT_ENABLE]));
	// level-triggered external lines, already gated by their enables
	assign pd_wake = ext_irq_line_zero || ext_irq_line_one;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// one pass computes every field of the next state
	always_comb begin
		n = s;
		n.pc_clear = 1'b0;
		n.flash_req = 1'b0;
		// reset pin synchroniser
		n.pin_meta = rst_pin;
		n.pin_sync = s.pin_meta;
		// machine cycle position
		if (s.mcyc == iprc_pkg::MCYC_LAST) begin
			n.mcyc = 4'h0;
		end else begin
			n.mcyc = s.mcyc + 4'h1;
		end
		// pin seen once per machine cycle, two highs in a row reset
		if (s.mcyc == iprc_pkg::STATE5_PHASE2) begin
			if (!s.pin_sync) begin
				n.hi_cnt = 2'h0;
			end else if (s.hi_cnt != iprc_pkg::RST_SAMPLES) begin
				n.hi_cnt = s.hi_cnt + 2'h1;
			end
		end
		n.core_rst = (s.hi_cnt == iprc_pkg::RST_SAMPLES) || soft_hit;
		// oscillator gain strap caught once after release
		if (!s.gain_taken) begin
			n.half_gain = !osc_gain_bit;
			n.gain_taken = 1'b1;
		end
		// unlock sequence
		if (wr_unlock) begin
			if (sfr_wdata == iprc_pkg::UNLOCK_FIRST) begin
				n.lock = iprc_pkg::LOCK_HALF;
			end else if (sfr_wdata == iprc_pkg::UNLOCK_SECOND &&
				s.lock != iprc_pkg::LOCK_CLOSED) begin
				n.lock = iprc_pkg::LOCK_OPEN;
			end else begin
				n.lock = iprc_pkg::LOCK_CLOSED;
			end
		end
		// control register only written while open
		if (wr_ispc && s.lock == iprc_pkg::LOCK_OPEN) begin
			n.ispc = sfr_wdata & iprc_pkg::ISP_CONTROL_WMASK;
		end
		// plain registers
		if (sfr_wr) begin
			case (sfr_addr)
				iprc_pkg::ADDR_FLASH_ADDR_LOW: n.addr_lo = sfr_wdata;
				iprc_pkg::ADDR_FLASH_ADDR_HIGH: n.addr_hi = sfr_wdata;
				iprc_pkg::ADDR_FLASH_DATA: n.fdata = sfr_wdata;
				iprc_pkg::ADDR_FLASH_COMMAND: begin
					n.fcmd = sfr_wdata & iprc_pkg::FLASH_COMMAND_WMASK;
				end
				iprc_pkg::ADDR_NIBBLE_PORT: n.nport = sfr_wdata[3:0];
				iprc_pkg::ADDR_POWER_CONTROL: n.power_control = sfr_wdata;
				default: n.nport = n.nport;
			endcase
		end
		// read data
		if (sfr_rd) begin
			case (sfr_addr)
				iprc_pkg::ADDR_POWER_CONTROL: n.rdata = s.power_control;
				iprc_pkg::ADDR_ISP_CONTROL: begin
					n.rdata = s.ispc;
					n.rdata[iprc_pkg::SOFT_RESET_BIT] = s.loader;
				end
				iprc_pkg::ADDR_FLASH_ADDR_LOW: n.rdata = s.addr_lo;
				iprc_pkg::ADDR_FLASH_ADDR_HIGH: n.rdata = s.addr_hi;
				iprc_pkg::ADDR_FLASH_DATA: n.rdata = s.fdata;
				iprc_pkg::ADDR_FLASH_COMMAND: n.rdata = s.fcmd;
				iprc_pkg::ADDR_NIBBLE_PORT: n.rdata = {4'h0, s.nport};
				iprc_pkg::ADDR_ISP_UNLOCK: begin
					n.rdata = {6'h00, s.lock};
				end
				default: n.rdata = iprc_pkg::RST_ZERO;
			endcase
		end
		// flash operation in progress
		if (s.flash_busy && flash_done) begin
			n.flash_busy = 1'b0;
			if (s.flash_is_read) begin
				n.fdata = flash_rdata;
			end
		end
		// interrupt-return redirection ends at the first return
		if (s.interrupt_return_zero && interrupt_return_exec) begin
			n.interrupt_return_zero = 1'b0;
		end
		// power mode machine
		case (s.pwr)
			iprc_pkg::PWR_RUN: begin
				if (wr_power_control && sfr_wdata[iprc_pkg::POWERDOWN_REQUEST_BIT]) begin
					n.pwr = iprc_pkg::PWR_DOWN;
					n.cpu_en = 1'b0;
					n.periph_en = 1'b0;
					n.osc_on = 1'b0;
				end else if (wr_power_control &&
					sfr_wdata[iprc_pkg::IDLE_REQUEST_BIT]) begin
					n.pwr = iprc_pkg::PWR_IDLE;
					n.cpu_en = 1'b0;
					// launch an operation on entering idle in isp mode
					if (s.isp_mode && op_valid && !s.flash_busy) begin
						n.flash_req = 1'b1;
						n.flash_busy = 1'b1;
						n.flash_is_read = (s.fcmd[3:0] == iprc_pkg::OP_READ);
					end
				end
			end
			iprc_pkg::PWR_IDLE: begin
				if (irq_any) begin
					n.pwr = iprc_pkg::PWR_RUN;
					n.cpu_en = 1'b1;
					n.power_control[iprc_pkg::IDLE_REQUEST_BIT] = 1'b0;
					// first wake with program enable moves to the loader
					if (s.ispc[iprc_pkg::PROGRAM_ENABLE] && !s.isp_mode) begin
						n.isp_mode = 1'b1;
						n.loader = 1'b1;
						n.pc_clear = 1'b1;
						n.interrupt_return_zero = 1'b1;
					end
				end
			end
			iprc_pkg::PWR_DOWN: begin
				if (pd_wake) begin
					n.pwr = iprc_pkg::PWR_RUN;
					n.cpu_en = 1'b1;
					n.periph_en = 1'b1;
					n.osc_on = 1'b1;
					n.power_control[iprc_pkg::POWERDOWN_REQUEST_BIT] = 1'b0;
				end
			end
			default: n.pwr = iprc_pkg::PWR_RUN;
		endcase
		// hardware or soft reset returns mode, lock, control, flash and port state to defaults; power control keeps bit 4 and clears the rest
		if (s.core_rst) begin
			n.pwr = iprc_pkg::PWR_RUN;
			n.cpu_en = 1'b1;
			n.periph_en = 1'b1;
			n.osc_on = 1'b1;
			n.lock = iprc_pkg::LOCK_CLOSED;
			// the power-on value stands through the extra reset cycle
			if (s.gain_taken) begin
				n.power_control = (s.power_control & iprc_pkg::POWER_CONTROL_KEEP) |
					iprc_pkg::RST_ZERO;
			end
			n.ispc = iprc_pkg::RST_ZERO;
			n.addr_lo = iprc_pkg::RST_ZERO;
			n.addr_hi = iprc_pkg::RST_ZERO;
			n.fdata = iprc_pkg::RST_ZERO;
			n.fcmd = iprc_pkg::RST_ZERO;
			n.nport = iprc_pkg::RST_NIBBLE_PORT;
			n.isp_mode = 1'b0;
			n.loader = 1'b0;
			n.pc_clear = 1'b0;
			n.interrupt_return_zero = 1'b0;
			n.flash_req = 1'b0;
			n.flash_busy = 1'b0;
			n.flash_is_read = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// synchronous reset to the constant state
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s <= ST_RST;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs, each a slice of the state register
	// ----------------------------------------------------------------
	assign sfr_rdata = s.rdata;
	assign cpu_clk_en = s.cpu_en;
	assign periph_clk_en = s.periph_en;
	assign osc_run = s.osc_on;
	assign osc_half_gain = s.half_gain;
	assign core_rst = s.core_rst;
	assign nibble_port_pins = s.nport;
	assign code_from_loader = s.loader;
	assign aux_ram_en = s.ispc[iprc_pkg::AUX_RAM_ENABLE];
	assign pc_clear = s.pc_clear;
	assign interrupt_return_to_zero = s.interrupt_return_zero;
	assign flash_req = s.flash_req;
	assign flash_bank = s.fcmd[iprc_pkg::BANK_SELECT];
	assign flash_op = s.fcmd[3:0];
	assign flash_addr = {s.addr_hi, s.addr_lo};
	assign flash_wdata = s.fdata;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_idle_stop;
		@(posedge core_clk) disable iff (sys_rst)
		(s.pwr == iprc_pkg::PWR_RUN && !s.core_rst && wr_power_control &&
		sfr_wdata == 8'h01) |=> (!cpu_clk_en && periph_clk_en);
	endproperty
	a_idle_stop: assert property (p_idle_stop)
		else $error("idle did not stop only the processor clock");

	property p_idle_wake;
		@(posedge core_clk) disable iff (sys_rst)
		(s.pwr == iprc_pkg::PWR_IDLE && irq_any) |=> cpu_clk_en;
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("interrupt did not end idle");

	property p_pd_stop;
		@(posedge core_clk) disable iff (sys_rst)
		(s.pwr == iprc_pkg::PWR_RUN && !s.core_rst && wr_power_control &&
		sfr_wdata[iprc_pkg::POWERDOWN_REQUEST_BIT])
		|=> (!osc_run && !periph_clk_en && !cpu_clk_en);
	endproperty
	a_pd_stop: assert property (p_pd_stop)
		else $error("power-down left a clock running");

	property p_pd_hold;
		@(posedge core_clk) disable iff (sys_rst)
		(s.pwr == iprc_pkg::PWR_DOWN && !pd_wake && !s.core_rst)
		|=> !osc_run;
	endproperty
	a_pd_hold: assert property (p_pd_hold)
		else $error("power-down ended without a wake source");

	property p_rst_filter;
		@(posedge core_clk) disable iff (sys_rst)
		(s.hi_cnt != iprc_pkg::RST_SAMPLES && !soft_hit) |=> !core_rst;
	endproperty
	a_rst_filter: assert property (p_rst_filter)
		else $error("reset taken without two high samples");

	property p_rst_values;
		@(posedge core_clk) disable iff (sys_rst)
		core_rst |=> (nibble_port_pins == 4'hF &&
		s.lock == iprc_pkg::LOCK_CLOSED && s.ispc == 8'h00);
	endproperty
	a_rst_values: assert property (p_rst_values)
		else $error("reset values not loaded");

	property p_unlock;
		@(posedge core_clk) disable iff (sys_rst)
		(wr_unlock && sfr_wdata == 8'h87 && !s.core_rst) ##1
		(wr_unlock && sfr_wdata == 8'h59 && !s.core_rst)
		|=> (s.lock == iprc_pkg::LOCK_OPEN);
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("unlock sequence did not open");

	property p_relock;
		@(posedge core_clk) disable iff (sys_rst)
		(wr_unlock && sfr_wdata != 8'h87 && sfr_wdata != 8'h59)
		|=> (s.lock == iprc_pkg::LOCK_CLOSED);
	endproperty
	a_relock: assert property (p_relock)
		else $error("bad unlock value did not relock");

	property p_locked_write;
		@(posedge core_clk) disable iff (sys_rst)
		(wr_ispc && s.lock != iprc_pkg::LOCK_OPEN && !s.core_rst)
		|=> $stable(s.ispc);
	endproperty
	a_locked_write: assert property (p_locked_write)
		else $error("locked control register changed");

	property p_soft_reset;
		@(posedge core_clk) disable iff (sys_rst)
		(wr_ispc && s.lock == iprc_pkg::LOCK_OPEN &&
		sfr_wdata[7] && sfr_wdata[1] && sfr_wdata[0]) |=> core_rst;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset not raised");

	property p_flash_idle;
		@(posedge core_clk) disable iff (sys_rst)
		flash_req |-> (s.pwr == iprc_pkg::PWR_IDLE && !cpu_clk_en);
	endproperty
	a_flash_idle: assert property (p_flash_idle)
		else $error("flash operation outside idle");

	property p_unlock_gap;
		@(posedge core_clk) disable iff (sys_rst)
		(wr_unlock && sfr_wdata == iprc_pkg::UNLOCK_FIRST && !s.core_rst)
		##1 (!wr_unlock && !s.core_rst) ##1
		(wr_unlock && sfr_wdata == iprc_pkg::UNLOCK_SECOND && !s.core_rst)
		|=> (s.lock == iprc_pkg::LOCK_OPEN);
	endproperty
	a_unlock_gap: assert property (p_unlock_gap)
		else $error("spaced unlock sequence did not open");

	property p_rst_low_sample;
		@(posedge core_clk) disable iff (sys_rst)
		(s.mcyc == iprc_pkg::STATE5_PHASE2 && !s.pin_sync) ##1 !soft_hit
		|=> !core_rst;
	endproperty
	a_rst_low_sample: assert property (p_rst_low_sample)
		else $error("reset held after a low pin sample");
endmodule : iprc_top

// ---- tb/iprc_flash_model.sv ----
// behavioural code memory array answering the programming requests
`timescale 1ns/100ps
module iprc_flash_model (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic flash_req,
	input wire logic flash_bank,
	input wire logic [3:0] flash_op,
	input wire logic [15:0] flash_addr,
	input wire logic [7:0] flash_wdata,
	output logic flash_done,
	output logic [7:0] flash_rdata
);
	// ----------------------------------------------------------------
	// array storage and operation timing
	// ----------------------------------------------------------------
	logic [7:0] mem [logic [16:0]];
	logic [16:0] key_q;
	logic [7:0] wd_q;
	logic [3:0] op_q;
	int cnt = 0;
	initial flash_done = 1'b0;
	initial flash_rdata = 8'h5A;
	// one operation at a time, done after a short or a long delay
	always @(posedge core_clk) begin
		flash_done <= 1'b0;
		flash_rdata <= ~flash_rdata; // no valid byte outside done
		if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				flash_done <= 1'b1;
				case (op_q)
				4'h1: mem[key_q] = wd_q;
				4'h2: foreach (mem[k]) begin
					if (k[16] == key_q[16]) mem[k] = 8'hFF;
				end
				default: flash_rdata <= mem.exists(key_q) ? mem[key_q] : 8'hFF;
				endcase
			end
		end else if (flash_req === 1'b1) begin
			cnt <= slow ? 20 : 2;
			key_q <= {flash_bank, flash_addr};
			op_q <= flash_op;
			wd_q <= flash_wdata;
		end
	end
endmodule : iprc_flash_model

// ---- tb/iprc_top_tb.sv ----
// self-checking bench for the power, reset and programming control
`timescale 1ns/100ps
module iprc_top_tb;
	// ----------------------------------------------------------------
	// signals, counters and tables
	// ----------------------------------------------------------------
	logic core_clk, sys_rst, rst_pin, sfr_wr, sfr_rd, irq_any, interrupt_return_exec;
	logic ext_irq_line_zero, ext_irq_line_one, osc_gain_bit, slow;
	logic flash_done, cpu_clk_en, periph_clk_en, osc_run, osc_half_gain;
	logic core_rst, code_from_loader, aux_ram_en, pc_clear, interrupt_return_to_zero;
	logic flash_req, flash_bank;
	logic [3:0] flash_op, nibble_port_pins;
	logic [7:0] sfr_addr, sfr_wdata, flash_rdata, sfr_rdata, flash_wdata;
	logic [15:0] flash_addr, f_addr;
	logic [28:0] cap;
	logic [31:0] seed = 32'h00011BB1;
	logic [7:0] f_data, v, c;
	logic [7:0] shadow [2] = '{8'hFF, 8'hFF};
	logic [7:0] ra [8] = '{8'h87, 8'hBF, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hF6,
		8'h80};
	logic [7:0] re [8] = '{8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00};
	logic [7:0] cmds [6] = '{8'h61, 8'h40, 8'h22, 8'h00, 8'h31, 8'h01};
	int err_total = 0, n_compared = 0, n_req = 0, n_done = 0, n_pcc = 0;
	int i;

	iprc_top iprc_top_i (.core_clk, .sys_rst, .rst_pin, .sfr_addr, .sfr_wr,
		.sfr_rd, .sfr_wdata, .irq_any, .ext_irq_line_zero, .ext_irq_line_one,
		.interrupt_return_exec, .osc_gain_bit, .flash_done, .flash_rdata, .sfr_rdata,
		.cpu_clk_en, .periph_clk_en, .osc_run, .osc_half_gain, .core_rst,
		.nibble_port_pins, .code_from_loader, .aux_ram_en, .pc_clear,
		.interrupt_return_to_zero, .flash_req, .flash_bank, .flash_op, .flash_addr,
		.flash_wdata);
	iprc_flash_model iprc_flash_model_i (.core_clk, .slow, .flash_req,
		.flash_bank, .flash_op, .flash_addr, .flash_wdata, .flash_done,
		.flash_rdata);

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// count requests, done pulses and program counter clears
	always @(posedge core_clk) begin
		if (flash_req === 1'b1) n_req++;
		if (flash_req === 1'b1) cap = {flash_bank, flash_op, flash_addr,
			flash_wdata};
		if (flash_done === 1'b1) n_done++;
		if (pc_clear === 1'b1) n_pcc++;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// a command starts the array only with chip enable low and right oe
	function automatic logic valid_cmd(input logic [7:0] k);
		if (k[4]) return 1'b0;
		if (k[3:0] == 4'h0) return !k[5];
		return (k[3:0] == 4'h1 || k[3:0] == 4'h2) && k[5];
	endfunction : valid_cmd
	task automatic test_done();
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// register bus write and read, one strobe cycle each
	task automatic wr(input logic [7:0] a, d);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge core_clk);
		sfr_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input string nm, input logic [7:0] a, e);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge core_clk);
		sfr_rd <= 1'b0;
		#1 check(nm, sfr_rdata, e);
	endtask : rd_chk
	task automatic unlock();
		wr(8'hF6, 8'h87);
		wr(8'hF6, 8'h59);
	endtask : unlock
	// raise an interrupt until the processor clock returns, or give up
	task automatic wake();
		@(posedge core_clk) irq_any <= 1'b1;
		for (int k = 0; k < 8 && cpu_clk_en !== 1'b1; k++) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk) irq_any <= 1'b0;
	endtask : wake
	task automatic wait_rst(input logic lvl, input int n);
		for (int k = 0; k < n && core_rst !== lvl; k++) begin
			@(posedge core_clk);
			#1;
		end
	endtask : wait_rst
	task automatic hold_low(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1 check("core_rst_low", core_rst, 1'b0);
		end
	endtask : hold_low
	// one programming operation carried out during an idle period
	task automatic isp_op(input logic [7:0] k);
		int r0;
		int d0;
		logic ok;
		logic [28:0] x;
		r0 = n_req;
		d0 = n_done;
		ok = valid_cmd(k);
		f_data = xs();
		wr(8'hC6, f_data);
		wr(8'hC7, k);
		check("req_outside_idle", n_req - r0, 0);
		wr(8'h87, 8'h01);
		repeat (4) @(posedge core_clk);
		check("flash_req", n_req - r0, ok);
		x = {k[6], k[3:0], f_addr, f_data};
		if (ok) check("flash_fields", cap, x);
		for (int j = 0; j < 40 && ok && n_done == d0; j++) begin
			@(posedge core_clk);
		end
		if (ok) check("flash_done", n_done - d0, 1);
		wake();
		if (ok && k[3:0] == 4'h1) shadow[k[6]] = f_data;
		if (ok && k[3:0] == 4'h2) shadow[k[6]] = 8'hFF;
		v = (ok && k[3:0] == 4'h0) ? shadow[k[6]] : f_data;
		rd_chk("flash_data", 8'hC6, v);
	endtask : isp_op

	// bounded run length
	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		test_done();
	end
	// main sequence
	initial begin
		sys_rst = 1'b1;
		rst_pin = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		irq_any = 1'b0;
		interrupt_return_exec = 1'b0;
		ext_irq_line_zero = 1'b0;
		ext_irq_line_one = 1'b0;
		slow = 1'b0;
		v = xs();
		osc_gain_bit = v[0];
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		check("nibble_port_pins", nibble_port_pins, 4'hF);
		check("osc_half_gain", osc_half_gain, !osc_gain_bit);
		check("code_from_loader", code_from_loader, 1'b0);
		foreach (ra[j]) rd_chk("reset_value", ra[j], re[j]);
		repeat (4) begin
			v = xs();
			wr(8'hD8, v);
			#1 check("nibble_port_pins", nibble_port_pins, v[3:0]);
		end
		wr(8'hBF, 8'h13);
		rd_chk("locked_write", 8'hBF, 8'h00);
		wr(8'hF6, 8'h59);
		wr(8'hBF, 8'h13);
		rd_chk("out_of_order", 8'hBF, 8'h00);
		unlock();
		rd_chk("lock_state", 8'hF6, 8'h02);
		wr(8'hBF, 8'h12);
		rd_chk("unlocked_write", 8'hBF, 8'h12);
		check("aux_ram_en", aux_ram_en, 1'b1);
		v = xs();
		if (v == 8'h87 || v == 8'h59) v = 8'h00;
		wr(8'hF6, v);
		wr(8'hBF, 8'h00);
		rd_chk("relocked", 8'hBF, 8'h12);
		wr(8'h87, 8'h01);
		#1 check("idle_en", {cpu_clk_en, periph_clk_en, osc_run}, 3'b011);
		repeat (3) @(posedge core_clk);
		wake();
		check("idle_wake", cpu_clk_en, 1'b1);
		// second pass sets the idle bit as well: power-down must win
		for (i = 0; i < 2; i++) begin
			wr(8'h87, 8'h02 + i[7:0]);
			#1 check("pd_en", {cpu_clk_en, periph_clk_en, osc_run}, 3'b000);
			wake();
			check("pd_irq", cpu_clk_en, 1'b0);
			@(posedge core_clk);
			ext_irq_line_zero <= (i == 0);
			ext_irq_line_one <= (i == 1);
			repeat (2) @(posedge core_clk);
			#1 check("pd_wake", {cpu_clk_en, periph_clk_en, osc_run}, 3'b111);
			@(posedge core_clk);
			ext_irq_line_zero <= 1'b0;
			ext_irq_line_one <= 1'b0;
		end
		unlock();
		wr(8'hBF, 8'h01);
		wr(8'h87, 8'h01);
		repeat (4) @(posedge core_clk);
		check("req_before_isp", n_req, 0);
		wake();
		repeat (2) @(posedge core_clk);
		#1 check("loader", {code_from_loader, interrupt_return_to_zero}, 2'b11);
		check("pc_clear_count", n_pcc, 1);
		rd_chk("isp_read", 8'hBF, 8'h81);
		@(posedge core_clk) interrupt_return_exec <= 1'b1;
		@(posedge core_clk) interrupt_return_exec <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 check("interrupt_return_to_zero", interrupt_return_to_zero, 1'b0);
		f_addr = xs();
		wr(8'hC5, f_addr[15:8]);
		wr(8'hC4, f_addr[7:0]);
		for (i = 0; i < 14; i++) begin
			c = (i < 6) ? cmds[i] : xs() & 8'h63;
			slow <= i[0];
			isp_op(c);
		end
		for (i = 0; i < 2; i++) begin
			wr(8'hBF, 8'h81 + i[7:0]);
			hold_low(3);
		end
		// soft reset is a one-cycle pulse right after the write lands
		wr(8'hBF, 8'h83);
		#1 check("soft_reset", core_rst, 1'b1);
		wait_rst(1'b0, 10);
		repeat (2) @(posedge core_clk);
		check("back_to_app", code_from_loader, 1'b0);
		wr(8'hBF, 8'h01);
		rd_chk("relock_after_reset", 8'hBF, 8'h00);
		v = xs();
		wr(8'h87, v & 8'h10);
		wr(8'hD8, 8'h00);
		wr(8'hC5, v);
		@(posedge core_clk) rst_pin <= 1'b1;
		@(posedge core_clk) rst_pin <= 1'b0;
		hold_low(30);
		@(posedge core_clk) rst_pin <= 1'b1;
		hold_low(12);
		wait_rst(1'b1, 20);
		check("pin_reset", core_rst, 1'b1);
		@(posedge core_clk) rst_pin <= 1'b0;
		wait_rst(1'b0, 40);
		repeat (2) @(posedge core_clk);
		check("port_after_reset", nibble_port_pins, 4'hF);
		rd_chk("power_keep_bit4", 8'h87, v & 8'h10);
		rd_chk("addr_high_reset", 8'hC5, 8'h00);
		rd_chk("lock_after_pin", 8'hF6, 8'h00);
		test_done();
	end
endmodule : iprc_top_tb
